// File: inc/ipcd_regs.svh
// timing, threshold and reset-value constants for the input pulse command decoder
`ifndef IPCD_REGS_SVH
`define IPCD_REGS_SVH

`define IPCD_CLK_HZ 40000000
`define IPCD_TICK_MS 1
`define IPCD_DEB_MS 20
`define IPCD_CNT_W 16
`define IPCD_CNT_RST 16'h0000
`define IPCD_CNT_MAX 16'hffff
`define IPCD_FB_MIN_MS 16'd800
`define IPCD_FB_MAX_MS 16'd1500
`define IPCD_DEV_MIN_MS 16'd4000
`define IPCD_DEV_MAX_MS 16'd6500
`define IPCD_ACK_ERR_MS 16'd3000
`define IPCD_ACK_DEV_MS 16'd15000
`define IPCD_N_ALARM 16

`endif

// File: inc/ipcd_pkg.sv
// types shared by the input pulse command decoder
`default_nettype none

package ipcd_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_RESET = 2'b01,
    MODE_ACK = 2'b10
  } ipcd_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HIGH = 1'b1
  } ipcd_state_t;

  typedef struct packed {
    logic fieldbus_reset;
    logic device_reset;
    logic warn_ack;
    logic err_ack;
    logic alarm_ack;
  } ipcd_req_t;

endpackage

`default_nettype wire

// File: logic/ipcd_sync.sv
// three-flop synchroniser and millisecond debouncer for the command input
`timescale 1ns/1ps
`default_nettype none

module ipcd_sync #(
  parameter int DEB_MS = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // timebase
  input wire logic tick,
  // pin and filtered level
  input wire logic pin,
  output logic level
);

  localparam int DW = $clog2(DEB_MS + 1);

  logic s1_q, s2_q, s3_q;
  logic level_q, level_d;
  logic [DW-1:0] deb_q, deb_d;

  always_comb begin
    level_d = level_q;
    deb_d = deb_q;
    if ((s2_q != s3_q) || (s3_q == level_q)) begin
      deb_d = '0;
    end else if (tick) begin
      if (deb_q == DW'(DEB_MS - 1)) begin
        level_d = s3_q;
        deb_d = '0;
      end else begin
        deb_d = deb_q + DW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      deb_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      deb_q <= deb_d;
    end
  end

  assign level = level_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_DEB_ON_TICK: assert property (
    (level_q != $past(level_q)) |-> ($past(tick) && $past(s2_q) == $past(s3_q)))
    else $error("filtered level changed without a stable tick");

endmodule // ipcd_sync

`default_nettype wire

// File: logic/ipcd_decoder.sv
// input pulse command decoder: pulse length to reset and acknowledge requests
`timescale 1ns/1ps
`default_nettype none
`include "ipcd_regs.svh"

// Operation
// - disabled mode: input ignored, no reset or acknowledge from it.
// - reset mode: a one second high pulse resets only the field-bus driver.
// - reset mode: a five second high pulse requests a complete device reset.
// - acknowledge mode: pulse ending before three seconds acknowledges all warnings.
// - acknowledge mode: high beyond three seconds acknowledges errors and alarms.
// - acknowledge mode: high beyond fifteen seconds triggers a complete device reset.
// - any error acknowledge also acknowledges every active alarm.
// - held alarm outputs stay on until acknowledged; others follow the alarm.
module ipcd_decoder #(
  parameter int TICK_CYCLES = `IPCD_CLK_HZ / 1000 * `IPCD_TICK_MS,
  parameter int DEB_MS = `IPCD_DEB_MS,
  parameter int N_ALARM = `IPCD_N_ALARM
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // command pin and its function
  input wire logic general_input_one,
  input wire ipcd_pkg::ipcd_mode_t cfg_mode,
  // acknowledge from other sources
  input wire logic ext_err_ack,
  // alarms
  input wire logic [N_ALARM-1:0] alarm_active,
  input wire logic [N_ALARM-1:0] alarm_hold,
  output logic [N_ALARM-1:0] alarm_out,
  // requests to the controller
  output ipcd_pkg::ipcd_req_t req
);

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam int CW = `IPCD_CNT_W;

  // millisecond timebase
  logic [DIV_W-1:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    div_d = div_q + DIV_W'(1);
    tick_d = 1'b0;
    if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // filtered input
  logic lvl;

  ipcd_sync #(
    .DEB_MS(DEB_MS)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .tick(tick_q),
    .pin(general_input_one),
    .level(lvl)
  );

  // pulse timer and classifier
  ipcd_pkg::ipcd_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  ipcd_pkg::ipcd_req_t req_q, req_d;
  logic active_mode;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    req_d = '0;
    unique case (cfg_mode)
      ipcd_pkg::MODE_RESET: active_mode = 1'b1;
      ipcd_pkg::MODE_ACK: active_mode = 1'b1;
      default: active_mode = 1'b0;
    endcase
    if (!active_mode) begin
      st_d = ipcd_pkg::ST_IDLE;
      cnt_d = `IPCD_CNT_RST;
    end else begin
      unique case (st_q)
        ipcd_pkg::ST_IDLE: begin
          if (lvl) begin
            st_d = ipcd_pkg::ST_HIGH;
            cnt_d = `IPCD_CNT_RST;
          end
        end
        ipcd_pkg::ST_HIGH: begin
          if (!lvl) begin
            st_d = ipcd_pkg::ST_IDLE;
            cnt_d = `IPCD_CNT_RST;
            if (cfg_mode == ipcd_pkg::MODE_RESET) begin
              if (cnt_q >= `IPCD_FB_MIN_MS && cnt_q <= `IPCD_FB_MAX_MS) begin
                req_d.fieldbus_reset = 1'b1;
              end
              if (cnt_q >= `IPCD_DEV_MIN_MS && cnt_q <= `IPCD_DEV_MAX_MS) begin
                req_d.device_reset = 1'b1;
              end
            end else if (cnt_q < `IPCD_ACK_ERR_MS) begin
              req_d.warn_ack = 1'b1;
            end
          end else if (tick_q) begin
            if (cnt_q != `IPCD_CNT_MAX) begin
              cnt_d = cnt_q + CW'(1);
            end
            if (cfg_mode == ipcd_pkg::MODE_ACK) begin
              if (cnt_q == `IPCD_ACK_ERR_MS) begin
                req_d.err_ack = 1'b1;
              end
              if (cnt_q == `IPCD_ACK_DEV_MS) begin
                req_d.device_reset = 1'b1;
              end
            end
          end
        end
      endcase
    end
    if (ext_err_ack) begin
      req_d.err_ack = 1'b1;
    end
    req_d.alarm_ack = req_d.err_ack;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ipcd_pkg::ST_IDLE;
      cnt_q <= `IPCD_CNT_RST;
      req_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
    end
  end

  // alarm outputs, set wins over acknowledge
  logic [N_ALARM-1:0] out_q, out_d;

  always_comb begin
    out_d = alarm_active | (out_q & alarm_hold & ~{N_ALARM{req_q.alarm_ack}});
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign alarm_out = out_q;
  assign req = req_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_OFF_SILENT: assert property (
    (cfg_mode != ipcd_pkg::MODE_RESET && cfg_mode != ipcd_pkg::MODE_ACK) |=>
      (!req_q.fieldbus_reset && !req_q.device_reset && !req_q.warn_ack &&
       (!req_q.err_ack || $past(ext_err_ack))))
    else $error("request issued while the input is disabled");

  AST_FB_WINDOW: assert property (
    req_q.fieldbus_reset |->
      ($past(cfg_mode) == ipcd_pkg::MODE_RESET && !$past(lvl) &&
       $past(cnt_q) >= `IPCD_FB_MIN_MS && $past(cnt_q) <= `IPCD_FB_MAX_MS))
    else $error("field-bus reset outside the one second window");

  AST_DEV_WINDOW: assert property (
    (req_q.device_reset && $past(cfg_mode) == ipcd_pkg::MODE_RESET) |->
      (!$past(lvl) && $past(cnt_q) >= `IPCD_DEV_MIN_MS &&
       $past(cnt_q) <= `IPCD_DEV_MAX_MS))
    else $error("device reset outside the five second window");

  AST_WARN_SHORT: assert property (
    req_q.warn_ack |->
      ($past(st_q) == ipcd_pkg::ST_HIGH && !$past(lvl) &&
       $past(cfg_mode) == ipcd_pkg::MODE_ACK && $past(cnt_q) < `IPCD_ACK_ERR_MS))
    else $error("warning acknowledge without a short pulse");

  AST_ERR_AT_3S: assert property (
    (st_q == ipcd_pkg::ST_HIGH && cfg_mode == ipcd_pkg::MODE_ACK && lvl && tick_q &&
     cnt_q == `IPCD_ACK_ERR_MS) |=> (req_q.err_ack && cnt_q == `IPCD_ACK_ERR_MS + 16'd1))
    else $error("error acknowledge missing after three seconds high");

  AST_DEV_AT_15S: assert property (
    (st_q == ipcd_pkg::ST_HIGH && cfg_mode == ipcd_pkg::MODE_ACK && lvl && tick_q &&
     cnt_q == `IPCD_ACK_DEV_MS) |=>
      (req_q.device_reset && (!req_q.err_ack || $past(ext_err_ack))))
    else $error("device reset missing after fifteen seconds high");

  AST_ALARM_WITH_ERR: assert property (
    req_q.err_ack |-> (req_q.alarm_ack && ($past(ext_err_ack) || !req_q.warn_ack)))
    else $error("error acknowledged without alarm acknowledge");

  AST_HOLD_UNTIL_ACK: assert property (
    (!req_q.alarm_ack && |(out_q & alarm_hold)) |=>
      ((out_q & $past(out_q & alarm_hold)) == $past(out_q & alarm_hold)))
    else $error("held alarm output dropped without acknowledge");

  AST_TICK_SPACING: assert property (
    tick_q |-> (div_q == '0) ##1 !tick_q)
    else $error("millisecond tick repeated too soon");

endmodule // ipcd_decoder

`default_nettype wire

// File: tb/ipcd_master.sv
// master control model driving the command input
`timescale 1ns/1ps
`default_nettype none

module ipcd_master #(
  parameter int MS_CYCLES = 2
) (
  // clock
  input wire logic mclk,
  // command pin
  output logic pin
);
  initial pin = 1'b0;

  // high pulse of given ms, then idle low
  task automatic pulse(input int ms);
    @(negedge mclk);
    pin = 1'b1;
    repeat (ms * MS_CYCLES) @(negedge mclk);
    pin = 1'b0;
  endtask
endmodule // ipcd_master

`default_nettype wire

// File: tb/test_input_pulse_command_decoder.sv
// self-checking bench for the input pulse command decoder
`timescale 1ns/1ps
`default_nettype none

module test_input_pulse_command_decoder;
  localparam int TK = 2;
  localparam int DEB = 2;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic pin;
  logic ext_err_ack = 1'b0;
  ipcd_pkg::ipcd_mode_t cfg_mode = ipcd_pkg::MODE_OFF;
  logic [15:0] alarm_active = 16'h0000;
  logic [15:0] alarm_hold = 16'h0000;
  logic [15:0] alarm_out;
  ipcd_pkg::ipcd_req_t req;
  int mismatches = 0;
  int tests_run = 0;
  int n_fb = 0;
  int n_dev = 0;
  int n_warn = 0;
  int n_err = 0;
  int n_alm = 0;

  always #12.5 mclk = ~mclk;

  ipcd_master #(.MS_CYCLES(TK)) m (.mclk(mclk), .pin(pin));

  ipcd_decoder #(.TICK_CYCLES(TK), .DEB_MS(DEB), .N_ALARM(16)) DUT (
    .mclk(mclk),
    .nrst(nrst),
    .general_input_one(pin),
    .cfg_mode(cfg_mode),
    .ext_err_ack(ext_err_ack),
    .alarm_active(alarm_active),
    .alarm_hold(alarm_hold),
    .alarm_out(alarm_out),
    .req(req)
  );

  // request pulse counters
  always @(posedge mclk) begin
    if (req.fieldbus_reset === 1'b1) n_fb++;
    if (req.device_reset === 1'b1) n_dev++;
    if (req.warn_ack === 1'b1) n_warn++;
    if (req.err_ack === 1'b1) n_err++;
    if (req.alarm_ack === 1'b1) n_alm++;
  end

  function automatic logic [19:0] cnts();
    return {n_fb[3:0], n_dev[3:0], n_warn[3:0], n_err[3:0], n_alm[3:0]};
  endfunction

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one pulse in a mode, counters cleared first
  task automatic go(input ipcd_pkg::ipcd_mode_t md, input int ms);
    {n_fb, n_dev, n_warn, n_err, n_alm} = '0;
    @(negedge mclk);
    cfg_mode = md;
    m.pulse(ms);
    repeat ((DEB + 20) * TK) @(negedge mclk);
  endtask

  task automatic t_alarm;
    @(negedge mclk);
    alarm_hold = 16'h00ff;
    alarm_active = 16'h0f0f;
    repeat (3) @(negedge mclk);
    check({4'h0, alarm_out}, 20'h00f0f);
    alarm_active = 16'h0000;
    repeat (3) @(negedge mclk);
    check({4'h0, alarm_out}, 20'h0000f);
    ext_err_ack = 1'b1;
    @(negedge mclk);
    ext_err_ack = 1'b0;
    repeat (3) @(negedge mclk);
    check({4'h0, alarm_out}, 20'h00000);
    check(cnts(), 20'h00011);
  endtask

  task automatic t_off;
    go(ipcd_pkg::MODE_OFF, 1000);
    check(cnts(), 20'h00000);
  endtask

  // unused mode code behaves as disabled
  task automatic t_rsv;
    go(ipcd_pkg::ipcd_mode_t'(2'b11), 1000);
    check(cnts(), 20'h00000);
  endtask

  // mid-run reset clears held alarm outputs and requests
  task automatic t_rst;
    {n_fb, n_dev, n_warn, n_err, n_alm} = '0;
    alarm_active = 16'h0001;
    @(negedge mclk);
    alarm_active = 16'h0000;
    @(negedge mclk);
    check({4'h0, alarm_out}, 20'h00001);
    nrst = 1'b0;
    @(negedge mclk);
    check({4'h0, alarm_out}, 20'h00000);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    check({4'h0, alarm_out}, 20'h00000);
    check(cnts(), 20'h00000);
  endtask

  task automatic t_fb;
    go(ipcd_pkg::MODE_RESET, 1000);
    check(cnts(), 20'h10000);
  endtask

  task automatic t_dev;
    go(ipcd_pkg::MODE_RESET, 5000);
    check(cnts(), 20'h01000);
  endtask

  task automatic t_gap;
    go(ipcd_pkg::MODE_RESET, 2500);
    check(cnts(), 20'h00000);
  endtask

  task automatic t_warn;
    go(ipcd_pkg::MODE_ACK, 1000);
    check(cnts(), 20'h00100);
  endtask

  task automatic t_err;
    go(ipcd_pkg::MODE_ACK, 3500);
    check(cnts(), 20'h00011);
  endtask

  task automatic t_long;
    go(ipcd_pkg::MODE_ACK, 16000);
    check(cnts(), 20'h01011);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    t_alarm;
    t_rst;
    t_off;
    t_rsv;
    t_fb;
    t_dev;
    t_gap;
    t_warn;
    t_err;
    t_long;
    end_sim;
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge mclk);
    mismatches++;
    end_sim;
  end
endmodule // test_input_pulse_command_decoder

`default_nettype wire
